// [include/tct_regs.svh]
// Register map, control word fields and reset values of the interval timer.
// Assumes inclusion by the design files; definitions only.
`ifndef TCT_REGS_SVH
`define TCT_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets on the two address select lines
// ----------------------------------------------------------------------------
`define TCT_ADDR_CNT0       2'h0
`define TCT_ADDR_CNT1       2'h1
`define TCT_ADDR_CNT2       2'h2
`define TCT_ADDR_CTRL       2'h3

// ----------------------------------------------------------------------------
// Mode-setting word fields
// ----------------------------------------------------------------------------
`define TCT_SEL_HI          7
`define TCT_SEL_LO          6
`define TCT_RL_HI           5
`define TCT_RL_LO           4
`define TCT_MODE_HI         3
`define TCT_MODE_LO         1
`define TCT_BCD_BIT         0
`define TCT_SEL_NONE        2'h3
`define TCT_RL_LATCH        2'h0
`define TCT_RL_LSB          2'h1
`define TCT_RL_MSB          2'h2
`define TCT_RL_BOTH         2'h3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define TCT_RST_OUT         1'b1
`define TCT_RST_RL          2'h3
`define TCT_RST_CNT         16'h0000
`define TCT_RST_PINS        19'h00007

`endif

// [include/tct_pkg.sv]
// Types shared by the interval timer design files.
// Assumes tct_regs.svh is on the include path.
package tct_pkg;

    typedef enum logic [2:0] {
        TCT_MODE0,
        TCT_MODE1,
        TCT_MODE2,
        TCT_MODE3,
        TCT_MODE4,
        TCT_MODE5
    } tct_mode_t;

    typedef struct packed {
        tct_mode_t   mode;
        logic        bcd;
        logic [1:0]  rl;
        logic [15:0] cnt;
        logic [15:0] init;
        logic [15:0] act;
        logic [15:0] latch;
        logic        latched;
        logic        wtog;
        logic        rtog;
        logic        loading;
        logic        pend;
        logic        run;
        logic        trig;
        logic        out;
    } tct_chan_t;

endpackage : tct_pkg

// [logic/tct_pin_sync.sv]
// Two-stage synchroniser for a group of pins, plus one delayed copy for edges.
// Assumes the pins are asynchronous to ref_clk_in.
`include "tct_regs.svh"

module tct_pin_sync #(
    parameter int          W   = 19,
    parameter logic [18:0] RST = `TCT_RST_PINS
) (
    input  wire logic         ref_clk_in,
    input  wire logic         reset_in,
    input  wire logic [W-1:0] pins_in,
    output logic      [W-1:0] level_out,
    output logic      [W-1:0] prev_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] level_r;
    logic [W-1:0] prev_r;

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            meta_r  <= RST[W-1:0];
            level_r <= RST[W-1:0];
            prev_r  <= RST[W-1:0];
        end else begin
            meta_r  <= pins_in;
            level_r <= meta_r;
            prev_r  <= level_r;
        end
    end

    assign level_out = level_r;
    assign prev_out  = prev_r;
endmodule : tct_pin_sync

// [logic/tct_timer.sv]
// Three-channel 16-bit programmable interval timer with an 8-bit host port.
// Assumes all pins are asynchronous and much slower than the 25 MHz ref_clk_in.
`include "tct_regs.svh"

// Behaviour
// - Write with both address lines high loads the mode-setting word register.
// - Top two bits select counter 0, 1 or 2; code 11 is invalid.
// - Byte-access 00 copies the running count into the holding register undisturbed.
// - Byte-access 01 low only, 10 high only, 11 low then high.
// - Mode bits 000 to 101 select modes zero to five.
// - Lowest bit picks 16-bit binary or four-decade BCD counting.
// - Mode 0: output low on mode write, high at terminal count.
// - Mode 0: low gate holds; reload stops after first byte, resumes after second.
// - Mode 1: output low after gate rise, high at terminal count; retriggerable.
// - Mode 1: new count waits for the next gate rise.
// - Mode 2: output low for the final clock; gate rise restarts.
// - Modes 2 to 4: new count takes effect from the next sequence.
// - Mode 3: high for (N+1)/2 clocks, low for (N-1)/2 clocks with odd N; N/2 clocks each with even N.
// - Mode 3: runs while gate high; gate rise restarts the sequence.
// - Mode 4: loading starts count while gate high; one low clock after terminal.
// - Mode 5: gate rise starts a sequence; one low clock at terminal count.
// - A loaded counter decrements once per count clock while enabled.
// - After a latch, reads return the held value; byte access is unchanged.
// - Access only with chip select low; strobes active low; address picks target.
// - Gate is a level enable and in some modes a start edge.
module tct_timer (
    input  wire logic       ref_clk_in,
    input  wire logic       reset_in,
    input  wire logic       cs_n_in,
    input  wire logic       rd_n_in,
    input  wire logic       wr_n_in,
    input  wire logic       addr_sel_lo_in,
    input  wire logic       addr_sel_hi_in,
    input  wire logic [7:0] data_in,
    input  wire logic [2:0] count_clk_in,
    input  wire logic [2:0] gate_in,
    output logic      [7:0] data_out,
    output logic            data_oe_out,
    output logic      [2:0] timer_out
);
    import tct_pkg::*;

    // ------------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------------
    function automatic logic [15:0] tct_dec(input logic [15:0] v, input logic bcd);
        logic [15:0] r;
        logic        brw;
        r   = v;
        brw = 1'b1;
        if (!bcd) begin
            r = v - 16'h0001;
        end else begin
            for (int d = 0; d < 4; d++) begin
                if (brw) begin
                    if (v[d*4 +: 4] == 4'h0) begin
                        r[d*4 +: 4] = 4'h9;
                    end else begin
                        r[d*4 +: 4] = v[d*4 +: 4] - 4'h1;
                        brw = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction : tct_dec

    // A zero count stands for the full range, as after a wrap.
    function automatic logic [16:0] tct_bin(input logic [15:0] v, input logic bcd);
        logic [16:0] r;
        r = 17'h00000;
        if (v == 16'h0000) begin
            r = bcd ? 17'h02710 : 17'h10000;
        end else if (!bcd) begin
            r = {1'b0, v};
        end else begin
            r = 17'({13'h0000, v[15:12]} * 17'h003e8 + {13'h0000, v[11:8]} * 17'h00064
                   + {13'h0000, v[7:4]} * 17'h0000a + {13'h0000, v[3:0]});
        end
        return r;
    endfunction : tct_bin

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic [18:0] pin_s;
    logic [18:0] pin_p;

    tct_pin_sync #(
        .W   (19),
        .RST (`TCT_RST_PINS)
    ) u_sync (
        .ref_clk_in (ref_clk_in),
        .reset_in   (reset_in),
        .pins_in    ({gate_in, count_clk_in, data_in, addr_sel_hi_in, addr_sel_lo_in,
                      wr_n_in, rd_n_in, cs_n_in}),
        .level_out  (pin_s),
        .prev_out   (pin_p)
    );

    logic       s_cs_n;
    logic [1:0] s_addr;
    logic [7:0] s_data;
    logic       data_oe_r;
    logic       wr_end;
    logic       rd_start;
    logic       rd_end;

    assign s_cs_n   = pin_s[0];
    assign s_addr   = pin_s[4:3];
    assign s_data   = pin_s[12:5];
    // A write takes effect at the trailing edge, when data has long settled.
    assign wr_end   = pin_s[2] & ~pin_p[2] & ~s_cs_n;
    assign rd_start = ~pin_s[1] & pin_p[1] & ~s_cs_n;
    assign rd_end   = data_oe_r & (pin_s[1] | s_cs_n);

    logic        ctrl_wr;
    logic [1:0]  ctrl_sel;

    assign ctrl_wr  = wr_end && (s_addr == `TCT_ADDR_CTRL);
    assign ctrl_sel = s_data[`TCT_SEL_HI:`TCT_SEL_LO];

    // ------------------------------------------------------------------------
    // Counter channels
    // ------------------------------------------------------------------------
    tct_chan_t ch_r   [3];
    tct_chan_t ch_nxt [3];

    for (genvar i = 0; i < 3; i++) begin : g_ch
        logic cev;
        logic grise;
        logic gate;
        logic trig_now;
        logic mine;

        assign cev   = pin_p[13+i] & ~pin_s[13+i];
        assign grise = pin_s[16+i] & ~pin_p[16+i];
        assign gate  = pin_s[16+i];
        assign mine  = (s_addr == 2'(i));
        assign trig_now = ch_r[i].trig | grise;

        always_comb begin
            logic [15:0] dn;
            tct_chan_t   c;
            c  = ch_r[i];
            dn = tct_dec(c.cnt, c.bcd);
            c.trig = trig_now;
            if (cev) begin
                c.trig = 1'b0;
                unique case (c.mode)
                    TCT_MODE0: begin
                        if (c.pend) begin
                            c.cnt  = c.init;
                            c.pend = 1'b0;
                            c.run  = 1'b1;
                        end else if (c.run && gate && !c.loading) begin
                            c.cnt = dn;
                            if (dn == 16'h0000) begin
                                c.out = 1'b1;
                            end
                        end
                    end
                    TCT_MODE1: begin
                        if (trig_now) begin
                            c.cnt = c.init;
                            c.act = c.init;
                            c.run = 1'b1;
                            c.out = 1'b0;
                        end else if (c.run) begin
                            c.cnt = dn;
                            if (dn == 16'h0000) begin
                                c.out = 1'b1;
                                c.run = 1'b0;
                            end
                        end
                    end
                    TCT_MODE2, TCT_MODE3: begin
                        if (trig_now || (c.pend && !c.run) || (c.run && gate
                            && c.cnt == 16'h0001)) begin
                            c.cnt  = c.init;
                            c.act  = c.init;
                            c.pend = 1'b0;
                            c.run  = gate;
                            c.out  = 1'b1;
                        end else if (c.run && gate) begin
                            c.cnt = dn;
                            if (c.mode == TCT_MODE2) begin
                                c.out = (dn != 16'h0001);
                            end else begin
                                c.out = tct_bin(dn, c.bcd)
                                        > (tct_bin(c.act, c.bcd) >> 1);
                            end
                        end
                    end
                    TCT_MODE4, TCT_MODE5: begin
                        c.out = 1'b1;
                        if ((c.mode == TCT_MODE5 && trig_now)
                            || (c.mode == TCT_MODE4 && c.pend && !c.run)) begin
                            c.cnt  = c.init;
                            c.act  = c.init;
                            c.pend = 1'b0;
                            c.run  = 1'b1;
                        end else if (c.run && (gate || c.mode == TCT_MODE5)) begin
                            c.cnt = dn;
                            if (dn == 16'h0000) begin
                                c.out = 1'b0;
                                c.run = 1'b0;
                            end
                        end
                    end
                    default: begin
                        c.run = 1'b0;
                    end
                endcase
            end
            // A read ending in the same cycle as a latch command must not clear the new latch.
            if (rd_end && mine) begin
                if (c.rl == `TCT_RL_BOTH) begin
                    c.rtog = ~c.rtog;
                end
                if (c.rl != `TCT_RL_BOTH || c.rtog == 1'b0) begin
                    c.latched = 1'b0;
                end
            end
            if (ctrl_wr && ctrl_sel == 2'(i)) begin
                if (s_data[`TCT_RL_HI:`TCT_RL_LO] == `TCT_RL_LATCH) begin
                    c.latch   = ch_r[i].cnt;
                    c.latched = 1'b1;
                    c.rtog    = 1'b0;
                end else begin
                    c.rl      = s_data[`TCT_RL_HI:`TCT_RL_LO];
                    c.bcd     = s_data[`TCT_BCD_BIT];
                    c.mode    = (s_data[`TCT_MODE_HI:`TCT_MODE_LO] > 3'h5)
                                ? tct_mode_t'({1'b0, s_data[2:1]})
                                : tct_mode_t'(s_data[`TCT_MODE_HI:`TCT_MODE_LO]);
                    c.out     = (c.mode != TCT_MODE0);
                    c.run     = 1'b0;
                    c.pend    = 1'b0;
                    c.trig    = 1'b0;
                    c.wtog    = 1'b0;
                    c.rtog    = 1'b0;
                    c.loading = 1'b0;
                    c.latched = 1'b0;
                end
            end
            if (wr_end && mine && s_addr != `TCT_ADDR_CTRL) begin
                unique case (c.rl)
                    `TCT_RL_LSB: begin
                        c.init = {8'h00, s_data};
                        c.pend = 1'b1;
                    end
                    `TCT_RL_MSB: begin
                        c.init = {s_data, 8'h00};
                        c.pend = 1'b1;
                    end
                    default: begin
                        if (!c.wtog) begin
                            c.init[7:0] = s_data;
                            c.loading   = (c.mode == TCT_MODE0);
                        end else begin
                            c.init[15:8] = s_data;
                            c.loading    = 1'b0;
                            c.pend       = 1'b1;
                        end
                        c.wtog = ~c.wtog;
                    end
                endcase
                if (c.mode == TCT_MODE0 && c.pend) begin
                    c.out = 1'b0;
                end
            end
            ch_nxt[i] = c;
        end

        always_ff @(posedge ref_clk_in or posedge reset_in) begin
            if (reset_in) begin
                ch_r[i] <= '{mode: TCT_MODE0, bcd: 1'b0, rl: `TCT_RST_RL,
                             cnt: `TCT_RST_CNT, init: `TCT_RST_CNT, act: `TCT_RST_CNT,
                             latch: `TCT_RST_CNT, out: `TCT_RST_OUT, default: 1'b0};
            end else begin
                ch_r[i] <= ch_nxt[i];
            end
        end

        assign timer_out[i] = ch_r[i].out;

        // --------------------------------------------------------------------
        // Checks
        // --------------------------------------------------------------------
        a_mode_zero_low: assert property (@(posedge ref_clk_in) disable iff (reset_in)
            ctrl_wr && ctrl_sel == 2'(i) && s_data[5:4] != 2'h0 && s_data[3:1] == 3'h0
            |=> !ch_r[i].out && !ch_r[i].run)
            else $error("mode zero write did not drop the output");
        a_latch_copy: assert property (@(posedge ref_clk_in) disable iff (reset_in)
            ctrl_wr && ctrl_sel == 2'(i) && s_data[5:4] == 2'h0
            |=> ch_r[i].latch == $past(ch_r[i].cnt) && ch_r[i].latched)
            else $error("latch command did not capture the count");
        a_latch_keeps_rl: assert property (@(posedge ref_clk_in) disable iff (reset_in)
            ctrl_wr && ctrl_sel == 2'(i) && s_data[5:4] == 2'h0
            |=> $stable(ch_r[i].rl) && $stable(ch_r[i].mode))
            else $error("latch command altered the byte access");
        a_hold_gate_low: assert property (@(posedge ref_clk_in) disable iff (reset_in)
            cev && !gate && ch_r[i].mode == TCT_MODE0 && !ch_r[i].pend && !wr_end
            |=> $stable(ch_r[i].cnt))
            else $error("mode zero counted with gate low");
        a_bin_decrement: assert property (@(posedge ref_clk_in) disable iff (reset_in)
            cev && gate && ch_r[i].mode == TCT_MODE0 && ch_r[i].run && !ch_r[i].pend
            && !ch_r[i].loading && !ch_r[i].bcd && !wr_end
            |=> ch_r[i].cnt == $past(ch_r[i].cnt) - 16'h0001)
            else $error("binary count did not step down by one");
        a_bcd_borrow: assert property (@(posedge ref_clk_in) disable iff (reset_in)
            cev && gate && ch_r[i].mode == TCT_MODE0 && ch_r[i].run && !ch_r[i].pend
            && !ch_r[i].loading && ch_r[i].bcd && ch_r[i].cnt[3:0] == 4'h0 && !wr_end
            |=> ch_r[i].cnt[3:0] == 4'h9)
            else $error("bcd digit did not borrow to nine");
        a_retrig_one: assert property (@(posedge ref_clk_in) disable iff (reset_in)
            cev && trig_now && ch_r[i].mode == TCT_MODE1 && !wr_end
            |=> !ch_r[i].out && ch_r[i].cnt == ch_r[i].init)
            else $error("gate rise did not retrigger mode one");
        a_rate_pulse: assert property (@(posedge ref_clk_in) disable iff (reset_in)
            ch_r[i].mode == TCT_MODE2 && $fell(ch_r[i].out) |-> ch_r[i].cnt == 16'h0001)
            else $error("rate pulse not at the final clock");

        c_mode3_wave: cover property (@(posedge ref_clk_in) disable iff (reset_in)
            ch_r[i].mode == TCT_MODE3 && $fell(ch_r[i].out));
        c_mode1_done: cover property (@(posedge ref_clk_in) disable iff (reset_in)
            ch_r[i].mode == TCT_MODE1 && $rose(ch_r[i].out));
    end

    // ------------------------------------------------------------------------
    // Host read port
    // ------------------------------------------------------------------------
    logic [7:0] data_out_r;
    logic [7:0] data_out_nxt;
    logic       data_oe_nxt;

    always_comb begin
        logic [15:0] v;
        tct_chan_t   c;
        v            = 16'h0000;
        c            = ch_r[0];
        data_out_nxt = data_out_r;
        data_oe_nxt  = data_oe_r;
        if (s_addr == `TCT_ADDR_CNT1) begin
            c = ch_r[1];
        end else if (s_addr == `TCT_ADDR_CNT2) begin
            c = ch_r[2];
        end
        // Without a latch the live count is read; the host must freeze it first.
        v = c.latched ? c.latch : c.cnt;
        if (rd_start && s_addr != `TCT_ADDR_CTRL) begin
            data_oe_nxt  = 1'b1;
            data_out_nxt = (c.rl == `TCT_RL_MSB || (c.rl == `TCT_RL_BOTH && c.rtog))
                           ? v[15:8] : v[7:0];
        end else if (rd_end) begin
            data_oe_nxt = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            data_out_r <= 8'h00;
            data_oe_r  <= 1'b0;
        end else begin
            data_out_r <= data_out_nxt;
            data_oe_r  <= data_oe_nxt;
        end
    end

    assign data_out    = data_out_r;
    assign data_oe_out = data_oe_r;

    a_drive_selected: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        data_oe_r && !$past(data_oe_r) |-> $past(!pin_s[1] && !s_cs_n))
        else $error("data driven without chip select and read");
    a_ctrl_invalid: assert property (@(posedge ref_clk_in) disable iff (reset_in)
        ctrl_wr && ctrl_sel == `TCT_SEL_NONE && !pin_s[13] && !pin_s[14] && !pin_s[15]
        && pin_p[15:13] == 3'h0 |=> $stable(ch_r[0].mode) && $stable(ch_r[1].rl)
        && $stable(ch_r[2].cnt))
        else $error("invalid counter select changed a counter");
    c_read_pair: cover property (@(posedge ref_clk_in) disable iff (reset_in)
        rd_end ##[1:200] rd_start);
endmodule : tct_timer

// [test/tct_host_model.sv]
// Host processor model: byte writes and reads on the timer's host port.
// Assumes one caller at a time, after reset, between clock edges.
module tct_host_model (
    input  wire logic       ref_clk_in,
    input  wire logic [7:0] rd_data_in,
    input  wire logic       rd_oe_in,
    output logic            cs_n_out,
    output logic            rd_n_out,
    output logic            wr_n_out,
    output logic      [1:0] addr_out,
    output logic      [7:0] host_data_out
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        {cs_n_out, rd_n_out, wr_n_out} = 3'h7;
        addr_out = 2'h0;
        host_data_out = 8'h00;
    end

    // Strobes stay low 6 clocks, as the two-flop sampling needs them seen twice.
    task automatic bus_write(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        cs_n_out <= 1'b0;
        addr_out <= a;
        host_data_out <= d;
        wr_n_out <= 1'b0;
        repeat (6) @(posedge ref_clk_in);
        wr_n_out <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        cs_n_out <= 1'b1;
        host_data_out <= ~d;
        repeat (6) @(posedge ref_clk_in);
    endtask : bus_write

    // One byte per call; the caller issues the byte sequence it programmed.
    task automatic bus_read(input logic [1:0] a, output logic [7:0] d,
                            output logic oe);
        @(posedge ref_clk_in);
        cs_n_out <= 1'b0;
        addr_out <= a;
        rd_n_out <= 1'b0;
        repeat (6) @(posedge ref_clk_in);
        d = rd_data_in;
        oe = rd_oe_in;
        rd_n_out <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        cs_n_out <= 1'b1;
        repeat (8) @(posedge ref_clk_in);
    endtask : bus_read
endmodule : tct_host_model

// [test/tct_timer_tb.sv]
// Self-checking bench for the interval timer, driven through the host model.
// Assumes the host model file and the design files are compiled first.
module tct_timer_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        ref_clk = 1'b0;
    logic        reset   = 1'b1;
    logic        cs_n, rd_n, wr_n, oe, rdoe;
    logic [1:0]  addr;
    logic [7:0]  wdata, rdata, lo, hi;
    logic [2:0]  cclk    = 3'h0;
    logic [2:0]  gate    = 3'h7;
    logic [2:0]  tout;
    logic [15:0] v;
    int          fail_count  = 0;
    int          check_count = 0;

    always #20 ref_clk = ~ref_clk;

    tct_timer tct_timer_inst (.ref_clk_in(ref_clk), .reset_in(reset), .cs_n_in(cs_n),
        .rd_n_in(rd_n), .wr_n_in(wr_n), .addr_sel_lo_in(addr[0]), .addr_sel_hi_in(addr[1]),
        .data_in(wdata), .count_clk_in(cclk), .gate_in(gate), .data_out(rdata),
        .data_oe_out(oe), .timer_out(tout));

    tct_host_model tct_host_model_inst (.ref_clk_in(ref_clk), .rd_data_in(rdata),
        .rd_oe_in(oe), .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n),
        .addr_out(addr), .host_data_out(wdata));

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        tct_host_model_inst.bus_write(a, d);
    endtask : wr

    task automatic rd(input logic [1:0] a);
        tct_host_model_inst.bus_read(a, lo, rdoe);
    endtask : rd

    task automatic rd16(input logic [1:0] a);
        tct_host_model_inst.bus_read(a, lo, rdoe);
        tct_host_model_inst.bus_read(a, hi, rdoe);
        v = {hi, lo};
    endtask : rd16

    // Each count event is the falling edge; both levels last well over 3 clocks.
    task automatic pulse(input int ch, input int n);
        repeat (n) begin
            cclk[ch] <= 1'b1;
            repeat (5) @(posedge ref_clk);
            cclk[ch] <= 1'b0;
            repeat (6) @(posedge ref_clk);
        end
    endtask : pulse

    // The low level must pass both synchroniser stages or the rise is never seen.
    task automatic grise(input int ch);
        gate[ch] <= 1'b0;
        repeat (4) @(posedge ref_clk);
        gate[ch] <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask : grise

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    // ------------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------------
    initial begin
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (3) @(posedge ref_clk);
        wr(2'h3, 8'h30);
        wr(2'h0, 8'h03);
        wr(2'h0, 8'h00);
        chk("out0 after load", 16'h0, tout[0]);
        pulse(0, 3);
        chk("out0 counting", 16'h0, tout[0]);
        pulse(0, 1);
        chk("out0 terminal", 16'h1, tout[0]);
        $display("test mode0 finished");
        wr(2'h3, 8'h74);
        wr(2'h1, 8'h34);
        wr(2'h1, 8'h12);
        pulse(1, 1);
        wr(2'h3, 8'h40);
        pulse(1, 2);
        rd16(2'h1);
        chk("latched count1", 16'h1234, v);
        gate[1] <= 1'b0;
        wr(2'h3, 8'hd0);
        rd16(2'h1);
        chk("direct count1", 16'h1232, v);
        $display("test latch finished");
        wr(2'h3, 8'h91);
        wr(2'h2, 8'h10);
        pulse(2, 2);
        gate[2] <= 1'b0;
        rd(2'h2);
        chk("bcd count2", 16'h0009, {8'h00, lo});
        $display("test bcd finished");
        wr(2'h3, 8'h12);
        wr(2'h0, 8'h02);
        grise(0);
        pulse(0, 1);
        chk("out0 one-shot low", 16'h0, tout[0]);
        pulse(0, 2);
        chk("out0 one-shot end", 16'h1, tout[0]);
        wr(2'h3, 8'h18);
        wr(2'h0, 8'h02);
        pulse(0, 3);
        chk("out0 soft strobe", 16'h0, tout[0]);
        pulse(0, 1);
        chk("out0 soft rest", 16'h1, tout[0]);
        wr(2'h3, 8'h1a);
        wr(2'h0, 8'h01);
        grise(0);
        pulse(0, 2);
        chk("out0 hard strobe", 16'h0, tout[0]);
        pulse(0, 1);
        chk("out0 hard rest", 16'h1, tout[0]);
        $display("test one-shot and strobes finished");
        gate[1] <= 1'b1;
        gate[2] <= 1'b1;
        wr(2'h3, 8'h54);
        wr(2'h1, 8'h03);
        pulse(1, 3);
        chk("out1 rate pulse", 16'h0, tout[1]);
        pulse(1, 1);
        chk("out1 rate reload", 16'h1, tout[1]);
        wr(2'h3, 8'h96);
        wr(2'h2, 8'h04);
        pulse(2, 2);
        chk("out2 square high", 16'h1, tout[2]);
        pulse(2, 2);
        chk("out2 square low", 16'h0, tout[2]);
        pulse(2, 1);
        chk("out2 square again", 16'h1, tout[2]);
        $display("test rate and square finished");
        rd(2'h3);
        chk("ctrl read drive", 16'h0, rdoe);
        $display("test refusal finished");
        test_done();
    end

    // The tests need about 730 clocks; over twenty-five times that means a hang.
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        test_done();
    end
endmodule : tct_timer_tb
